// File: sgs_arb.sv
// Priority arbiter choosing the pending group head to start next.
// Assumes request and priority vectors from the sequencer, same clock.
`timescale 1ns/100ps
module sgs_arb (
  // Requests
  input wire logic [sgs_pkg::NCH-1:0] req_i,
  input wire logic [sgs_pkg::NCH*4-1:0] prio_i,
  // Grant
  output logic gnt_o,
  output logic [sgs_pkg::CHW-1:0] gch_o
);
  import sgs_pkg::*;
  always_comb begin
    logic [3:0] best;
    best = 4'hf;
    gnt_o = 1'b0;
    gch_o = '0;
    for (int i = 0; i < NCH; i++) begin
      // Lower value wins, lowest channel on ties
      if (req_i[i] && (!gnt_o || prio_i[i*4 +: 4] < best)) begin
        gnt_o = 1'b1;
        best = prio_i[i*4 +: 4];
        gch_o = CHW'(i);
      end
    end
  end
endmodule

// File: sgs_conv_model.sv
// Converter core stand-in: answers each start with one done pulse.
// Assumes starts come one at a time on the sequencer's own clock.
`timescale 1ns/100ps
module sgs_conv_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // From the sequencer
  input wire logic start_i,
  input wire logic [sgs_pkg::PINW-1:0] pin_i,
  // Bench settings
  input wire logic [7:0] lat_i,
  input wire logic range_flag_i,
  input wire logic pulse_flag_i,
  // To the sequencer
  output logic done_o,
  output logic range_o,
  output logic pulse_o
);
  import sgs_pkg::*;
  logic [PINW-1:0] log_q[$];
  logic [7:0] cnt;
  logic busy;
  initial begin
    done_o = 1'h0;
    range_o = 1'h0;
    pulse_o = 1'h1;
    busy = 1'h0;
    cnt = 8'h00;
  end
  // Flags only count with done, so they wander in between
  always @(posedge clk_i) begin
    done_o <= 1'h0;
    range_o <= ~range_o;
    pulse_o <= ~pulse_o;
    if (!nrst_i) begin
      busy <= 1'h0;
    end else if (start_i) begin
      busy <= 1'h1;
      cnt <= lat_i;
      log_q.push_back(pin_i);
    end else if (busy && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy) begin
      busy <= 1'h0;
      done_o <= 1'h1;
      range_o <= range_flag_i;
      pulse_o <= pulse_flag_i;
    end
  end
endmodule

// File: sgs_pkg.sv
// Constants for the ADC group sequencer: register map, fields, states.
// Assumes a 32-bit APB bus with byte addresses and one clock domain.
package sgs_pkg;
  localparam int NCH = 8;
  localparam int CHW = 3;
  localparam int PINW = 5;
  // Per-channel register block: base + channel * stride
  localparam logic [11:0] CH_BASE = 12'h000;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [3:0] OFS_CTL = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_MASK = 4'hc;
  localparam logic [11:0] ADDR_BUSY = 12'h100;
  // Control register fields
  localparam int F_TRIG = 0;
  localparam int F_PRIO = 4;
  localparam int F_LAST = 8;
  localparam int F_LEVEL = 9;
  localparam int F_EN = 10;
  localparam int F_PIN = 16;
  localparam logic [31:0] CTL_RESET = 32'h0000_0100;
  // Interrupt cause bits
  localparam int I_GDONE = 0;
  localparam int I_GCAN = 1;
  localparam int I_GOVF = 2;
  localparam int I_RANGE = 3;
  localparam int I_PULSE = 4;
  localparam int I_COVF = 5;
  localparam int NIRQ = 6;
  // Trigger source encodings
  localparam logic [2:0] TRIG_OFF = 3'h0;
  localparam logic [2:0] TRIG_TIMER = 3'h1;
  localparam logic [2:0] TRIG_GEN0 = 3'h2;
  localparam logic [2:0] TRIG_GEN4 = 3'h6;
  localparam logic [2:0] TRIG_CONT = 3'h7;
  localparam int NGEN = 5;
  localparam logic [3:0] PRIO_HIGHEST = 4'h0;
  typedef enum logic [1:0] {
    SGS_IDLE = 2'b00,
    SGS_START = 2'b01,
    SGS_WAIT = 2'b10
  } sgs_state_t;
endpackage

// File: sgs_top.sv
// ADC group sequencer: APB registers, trigger decode, group walk, irqs.
// Assumes a converter core answering conv_start_o with conv_done_i.
`timescale 1ns/100ps
// How it works
// - One trigger converts a whole group of channels in turn.
// - Each channel drives its own analog pin select when converted.
// - Only the first channel's trigger setting starts its group.
// - Triggers are off, timer, generic 0 to 4, or continuous.
// - A last-marked channel or channel 7 ends the group; else the next one follows, or the group is cancelled if it is disabled.
// - Each finished conversion starts the next group member itself.
// - Priority value 0 wins arbitration between pending groups.
// - Each channel has six maskable interrupt causes; bit I_COVF is never set.
// - Each channel's done output is either a level or a pulse.
// - One software start on the first channel runs the whole group.
module sgs_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Trigger inputs from pins
  input wire logic timer_trig_i,
  input wire logic [sgs_pkg::NGEN-1:0] gen_trig_i,
  // Converter core, same clock
  output logic conv_start_o,
  output logic [sgs_pkg::PINW-1:0] conv_pin_o,
  input wire logic conv_done_i,
  input wire logic conv_range_i,
  input wire logic conv_pulse_i,
  // Per-channel done and one combined interrupt
  output logic [sgs_pkg::NCH-1:0] ch_done_o,
  output logic irq_o
);
  import sgs_pkg::*;
  function automatic logic trig_hit(input logic [2:0] sel,
                                    input logic tmr,
                                    input logic [NGEN-1:0] gen);
    logic hit;
    hit = 1'b0;
    case (sel)
      TRIG_TIMER: hit = tmr;
      TRIG_CONT: hit = 1'b1;
      default: begin
        if (sel >= TRIG_GEN0 && sel <= TRIG_GEN4) begin
          hit = gen[sel - TRIG_GEN0];
        end
      end
    endcase
    return hit;
  endfunction
  // Pin synchronisers
  logic [NGEN:0] sync1, sync2, sync3;
  logic [NGEN:0] trig_rise;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {timer_trig_i, gen_trig_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign trig_rise = sync2 & ~sync3;
  // Registers
  logic [31:0] ctl [NCH];
  logic [NIRQ-1:0] stat [NCH];
  logic [NIRQ-1:0] mask [NCH];
  logic [NCH-1:0] pend, busy, done_q;
  logic [NCH-1:0] next_pend, next_busy, next_done;
  logic [NIRQ-1:0] next_stat [NCH];
  logic [31:0] next_ctl [NCH];
  logic [NIRQ-1:0] next_mask [NCH];
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  logic irq, next_irq;
  // Sequencer state
  sgs_state_t st, next_st;
  logic [CHW-1:0] head, cur, next_head, next_cur;
  logic cstart, next_cstart;
  logic [PINW-1:0] cpin, next_cpin;
  logic gnt;
  logic [CHW-1:0] gch;
  logic [NCH*4-1:0] prio_vec;
  logic [NCH-1:0] req_vec;
  logic [NCH-1:0] irq_vec;
  wire acc = psel_i && !penable_i;
  wire [CHW-1:0] a_ch = paddr_i[4+CHW-1:4];
  wire a_in_ch = (paddr_i[11:4+CHW] == '0);
  wire [3:0] a_ofs = paddr_i[3:0];
  for (genvar g = 0; g < NCH; g++) begin : g_vec
    assign prio_vec[g*4 +: 4] = ctl[g][F_PRIO +: 4];
    assign req_vec[g] = pend[g] && ctl[g][F_EN];
    assign irq_vec[g] = |(stat[g] & mask[g]);
  end
  sgs_arb u_arb (
    .req_i(req_vec),
    .prio_i(prio_vec),
    .gnt_o(gnt),
    .gch_o(gch)
  );
  always_comb begin
    logic hw_hit;
    logic is_head;
    hw_hit = 1'b0;
    is_head = 1'b0;
    next_pend = pend;
    next_busy = busy;
    next_done = '0;
    next_st = st;
    next_head = head;
    next_cur = cur;
    next_cstart = 1'b0;
    next_cpin = cpin;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      next_ctl[i] = ctl[i];
      next_mask[i] = mask[i];
      next_stat[i] = stat[i];
      // Level style holds done until status is read
      next_done[i] = ctl[i][F_LEVEL] && done_q[i];
    end
    // APB access: no wait state, answer in the access phase
    if (acc) begin
      next_pready = 1'b1;
      next_prdata = '0;
      if (paddr_i == ADDR_BUSY) begin
        next_prdata = 32'(busy);
      end else if (!a_in_ch || paddr_i[1:0] != 2'b00) begin
        next_pslverr = 1'b1;
      end else begin
        case (a_ofs)
          OFS_CTL: begin
            if (pwrite_i) next_ctl[a_ch] = pwdata_i;
            else next_prdata = ctl[a_ch];
          end
          OFS_CMD: begin
            // Software start honoured on any channel not busy or pending
            if (pwrite_i && pwdata_i[0]) begin
              if (busy[a_ch] || pend[a_ch]) begin
                next_stat[a_ch][I_GOVF] = 1'b1;
              end else begin
                next_pend[a_ch] = 1'b1;
              end
            end
          end
          OFS_STAT: begin
            if (!pwrite_i) begin
              next_prdata = 32'(stat[a_ch]);
              next_stat[a_ch] = '0;
              next_done[a_ch] = 1'b0;
            end
          end
          OFS_MASK: begin
            if (pwrite_i) next_mask[a_ch] = pwdata_i[NIRQ-1:0];
            else next_prdata = 32'(mask[a_ch]);
          end
          default: next_pslverr = 1'b1;
        endcase
      end
    end
    // Hardware triggers examine only each channel's own setting
    for (int i = 0; i < NCH; i++) begin
      is_head = (i == 0) || ctl[(i + NCH - 1) % NCH][F_LAST];
      hw_hit = trig_hit(ctl[i][F_TRIG +: 3], trig_rise[NGEN],
                        trig_rise[NGEN-1:0]);
      if (ctl[i][F_TRIG +: 3] == TRIG_CONT) begin
        hw_hit = !busy[i] && !pend[i];
      end
      // Only a group head can start a group
      if (hw_hit && is_head && ctl[i][F_EN]) begin
        if (busy[i] || pend[i]) next_stat[i][I_GOVF] = 1'b1;
        else next_pend[i] = 1'b1;
      end
    end
    case (st)
      SGS_IDLE: begin
        if (gnt) begin
          // Highest priority pending head
          next_head = gch;
          next_cur = gch;
          next_pend[gch] = 1'b0;
          next_busy[gch] = 1'b1;
          next_st = SGS_START;
        end
      end
      SGS_START: begin
        next_cstart = 1'b1;
        next_cpin = ctl[cur][F_PIN +: PINW];
        next_st = SGS_WAIT;
      end
      SGS_WAIT: begin
        if (conv_done_i) begin
          next_done[cur] = 1'b1;
          if (conv_range_i) next_stat[cur][I_RANGE] = 1'b1;
          if (conv_pulse_i) next_stat[cur][I_PULSE] = 1'b1;
          if (ctl[cur][F_LAST] || cur == CHW'(NCH-1)) begin
            // Group finished
            next_stat[cur][I_GDONE] = 1'b1;
            next_busy[head] = 1'b0;
            next_st = SGS_IDLE;
          end else if (!ctl[cur+1][F_EN]) begin
            next_stat[cur][I_GCAN] = 1'b1;
            next_busy[head] = 1'b0;
            next_st = SGS_IDLE;
          end else begin
            // Chain to next member without a trigger
            next_cur = cur + 1'b1;
            next_st = SGS_START;
          end
        end
      end
      default: next_st = SGS_IDLE;
    endcase
    next_irq = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      next_irq = next_irq | (|(next_stat[i] & next_mask[i]));
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NCH; i++) begin
        ctl[i] <= CTL_RESET;
        stat[i] <= '0;
        mask[i] <= '0;
      end
      pend <= '0;
      busy <= '0;
      done_q <= '0;
      st <= SGS_IDLE;
      head <= '0;
      cur <= '0;
      cstart <= 1'b0;
      cpin <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ctl[i] <= next_ctl[i];
        stat[i] <= next_stat[i];
        mask[i] <= next_mask[i];
      end
      pend <= next_pend;
      busy <= next_busy;
      done_q <= next_done;
      st <= next_st;
      head <= next_head;
      cur <= next_cur;
      cstart <= next_cstart;
      cpin <= next_cpin;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end
  assign prdata_o = prdata;
  assign pready_o = pready;
  assign pslverr_o = pslverr;
  assign conv_start_o = cstart;
  assign conv_pin_o = cpin;
  assign ch_done_o = done_q;
  assign irq_o = irq;
  // Checks
  property p_chain;
    @(posedge clk_i) disable iff (!nrst_i)
    (st == SGS_WAIT && conv_done_i && !ctl[cur][F_LAST]
     && cur != CHW'(NCH-1) && ctl[cur+1][F_EN])
    |=> ##1 (conv_start_o && $past(cur, 2) + 1'b1 == cur);
  endproperty
  a_chain: assert property (p_chain) else $error("no chain start");
  property p_last;
    @(posedge clk_i) disable iff (!nrst_i)
    (st == SGS_WAIT && conv_done_i && ctl[cur][F_LAST])
    |=> st == SGS_IDLE && stat[$past(cur)][I_GDONE];
  endproperty
  a_last: assert property (p_last) else $error("group not ended");
  property p_one_start;
    @(posedge clk_i) disable iff (!nrst_i)
    conv_start_o |=> !conv_start_o;
  endproperty
  a_one_start: assert property (p_one_start) else $error("double start");
  property p_pin;
    @(posedge clk_i) disable iff (!nrst_i)
    conv_start_o |-> conv_pin_o == $past(ctl[cur][F_PIN +: PINW]);
  endproperty
  a_pin: assert property (p_pin) else $error("wrong pin");
  property p_grant;
    @(posedge clk_i) disable iff (!nrst_i)
    (st == SGS_IDLE && gnt) |-> prio_vec[gch*4 +: 4] <= prio_vec[0 +: 4]
      || !req_vec[0];
  endproperty
  a_grant: assert property (p_grant) else $error("bad priority");
  property p_irq;
    @(posedge clk_i) disable iff (!nrst_i)
    irq_o == (|irq_vec);
  endproperty
  a_irq: assert property (p_irq) else $error("irq lost");
  property p_busy_start;
    @(posedge clk_i) disable iff (!nrst_i)
    (st == SGS_IDLE && gnt) |=> busy[$past(gch)] && !pend[$past(gch)];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("no busy");
  property p_pulse;
    @(posedge clk_i) disable iff (!nrst_i)
    (ch_done_o[0] && !ctl[0][F_LEVEL]) |=> !ch_done_o[0] || $past(conv_done_i);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse held");
  property p_apb;
    @(posedge clk_i) disable iff (!nrst_i)
    (psel_i && !penable_i) |=> pready_o;
  endproperty
  a_apb: assert property (p_apb) else $error("apb no answer");
  c_group: cover property (@(posedge clk_i) disable iff (!nrst_i)
    st == SGS_WAIT && conv_done_i && ctl[cur][F_LAST] && cur != head);
  c_ovf: cover property (@(posedge clk_i) disable iff (!nrst_i)
    stat[0][I_GOVF]);
  c_irq: cover property (@(posedge clk_i) disable iff (!nrst_i) irq_o);
endmodule

// File: test_sar_adc_group_sequencer.sv
// Self-checking bench for the ADC group sequencer and a core stand-in.
// Assumes the sequencer package and design files are compiled first.
`timescale 1ns/100ps
module test_sar_adc_group_sequencer;
  import sgs_pkg::*;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic timer_trig_i, conv_start_o, conv_done_i, conv_range_i;
  logic conv_pulse_i, irq_o, rf, pf, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [NGEN-1:0] gen_trig_i;
  logic [PINW-1:0] conv_pin_o;
  logic [PINW-1:0] pins [NCH];
  logic [NCH-1:0] ch_done_o;
  logic [7:0] lat;
  int miscompares, n_compared, hi, lc, s, base;

  sgs_top DUT (.*);
  sgs_conv_model CORE (.clk_i(clk_i), .nrst_i(nrst_i),
    .start_i(conv_start_o), .pin_i(conv_pin_o), .lat_i(lat),
    .range_flag_i(rf), .pulse_flag_i(pf), .done_o(conv_done_i),
    .range_o(conv_range_i), .pulse_o(conv_pulse_i));

  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  always @(negedge clk_i) begin
    if (ch_done_o[lc] === 1'h1) begin
      hi++;
    end
  end

  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    // Answer read mid-cycle, before the edge that completes it
    @(negedge clk_i);
    while (pready_o !== 1'h1) begin
      @(negedge clk_i);
    end
    rd = prdata_o;
    er = pslverr_o;
    @(posedge clk_i);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  function automatic logic [11:0] ra(int c, int o);
    return 12'(CH_BASE + CH_STRIDE * c + o);
  endfunction

  function automatic logic [31:0] mk(int tr, int pr, int lst, int lv, int pn);
    return 32'(tr) << F_TRIG | 32'(pr) << F_PRIO | 32'(lst) << F_LAST
      | 32'(lv) << F_LEVEL | 32'h1 << F_EN | 32'(pn) << F_PIN;
  endfunction

  task automatic fire(int code);
    @(posedge clk_i);
    if (code == 1) begin
      timer_trig_i <= 1'h1;
    end else begin
      gen_trig_i <= NGEN'(1) << (code - 2);
    end
    repeat (3) @(posedge clk_i);
    timer_trig_i <= 1'h0;
    gen_trig_i <= '0;
  endtask

  task automatic grp(int code, int lvl, int msk, int len);
    int last;
    int e;
    s = $urandom_range(NCH - len, 0);
    last = s + len - 1;
    lat <= (code == 0) ? 8'h14 : 8'($urandom_range(12, 0));
    rf <= 1'($urandom);
    pf <= 1'($urandom);
    for (int c = s; c <= last; c++) begin
      pins[c] = PINW'($urandom);
      apb(1, ra(c, OFS_CTL), mk(c == s ? code : 1, 0, c == last, lvl,
        pins[c]));
      apb(1, ra(c, OFS_MASK), c == last ? msk << I_GDONE : 0);
      apb(0, ra(c, OFS_STAT), 0);
    end
    lc = last;
    base = CORE.log_q.size();
    hi = 0;
    if (code == 0) begin
      fire(1);
      repeat (8) @(posedge clk_i);
      check("member trigger", CORE.log_q.size(), base);
      apb(1, ra(s, OFS_CMD), 1);
      apb(1, ra(s, OFS_CMD), 1);
    end else begin
      fire(code);
    end
    for (e = 0; e < 3000 && ch_done_o[last] !== 1'h1; e++) begin
      @(negedge clk_i);
    end
    check("group end", e < 3000, 1);
    repeat (3) @(posedge clk_i);
    check("irq level", irq_o, msk);
    check("conversions", CORE.log_q.size(), base + len);
    for (int c = s; c <= last; c++) begin
      check("pin", CORE.log_q[base + c - s], pins[c]);
    end
    e = rf << I_RANGE | pf << I_PULSE;
    if (code == 0 && s != last) begin
      apb(0, ra(s, OFS_STAT), 0);
      check("head stat", rd, e | 1 << I_GOVF);
    end
    if (code == 0 && s == last) begin
      e = e | 1 << I_GOVF;
    end
    if (lvl == 1) begin
      check("done level", ch_done_o[last], 1);
    end
    apb(0, ra(last, OFS_STAT), 0);
    check("last stat", rd, e | 1 << I_GDONE);
    repeat (2) @(posedge clk_i);
    check("irq cleared", irq_o, 0);
    if (lvl == 1) begin
      check("done dropped", ch_done_o[last], 0);
    end else begin
      check("done pulse", hi, 1);
    end
    for (int c = s; c <= last; c++) begin
      apb(1, ra(c, OFS_CTL), CTL_RESET);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  initial begin
    void'($urandom(32'h2f7a2048));
    {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {timer_trig_i, gen_trig_i, lat, rf, pf} = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'h1;
    check("irq in reset", irq_o, 0);
    apb(0, ra(3, OFS_CTL), 0);
    check("ctl reset", rd, CTL_RESET);
    apb(0, ADDR_BUSY, 0);
    check("busy reset", rd, 0);
    apb(1, 12'h200, 32'hffff_ffff);
    check("unmapped write err", er, 1);
    apb(0, 12'h200, 0);
    check("unmapped read", rd, 0);
    for (int i = 0; i < 7; i++) begin
      grp(i, i % 2, $urandom_range(1, 0), $urandom_range(3, 1));
    end
    grp(0, 1, 1, NCH);
    // Two heads pending behind a slow conversion on channel 0
    lat <= 8'h28;
    apb(1, ra(0, OFS_CTL), mk(0, 5, 1, 0, 1));
    apb(1, ra(5, OFS_CTL), mk(0, 9, 1, 0, 5));
    apb(1, ra(7, OFS_CTL), mk(0, 0, 1, 0, 7));
    base = CORE.log_q.size();
    apb(1, ra(0, OFS_CMD), 1);
    apb(1, ra(5, OFS_CMD), 1);
    apb(1, ra(7, OFS_CMD), 1);
    for (int e = 0; e < 500 && CORE.log_q.size() < base + 3; e++) begin
      @(posedge clk_i);
    end
    check("first grant", CORE.log_q[base + 1], 7);
    check("second grant", CORE.log_q[base + 2], 5);
    // Next member disabled: group is cancelled after the head
    apb(0, ra(1, OFS_STAT), 0);
    apb(1, ra(1, OFS_CTL), mk(0, 0, 0, 0, 2));
    apb(1, ra(1, OFS_CMD), 1);
    repeat (150) @(posedge clk_i);
    apb(0, ra(1, OFS_STAT), 0);
    check("cancelled", rd,
      1 << I_GCAN | rf << I_RANGE | pf << I_PULSE);
    lat <= 8'h02;
    base = CORE.log_q.size();
    apb(1, ra(3, OFS_CTL), mk(TRIG_CONT, 0, 1, 0, 9));
    repeat (60) @(posedge clk_i);
    apb(1, ra(3, OFS_CTL), CTL_RESET);
    check("continuous", CORE.log_q.size() > base + 3, 1);
    close_out();
  end
endmodule
